//--- logic/cpu_core_pkg.sv
// Constants and types shared by the CPU addressing and low power logic
// Overview of operation
// RULE1: Standby stops instruction clock; oscillator, interrupts and timers keep going.
// RULE2: Standby holds registers, RAM and port states unchanged.
// RULE3: Reset during standby ends it and fully resets the device.
// RULE4: Interrupt wakes standby; serviced if enabled, else left pending.
// RULE5: Unserviced wake resumes at instruction after standby instruction.
// RULE6: Stop instruction halts oscillator, timers and interrupt logic.
// RULE7: Only reset leaves stop; reset held until oscillator settles.
// RULE8: RAM survives stop; A, B, W, Y, Y-spare, carry may be lost.
// RULE9: Register indirect address is W, X, Y concatenated to 10 bits.
// RULE10: Direct addressing takes the whole 10-bit second word as address.
// RULE11: Sixteen-digit memory-register window reached only by its two instructions; here direct and indirect addressing reach it too.
// RULE12: Long jump, branch, call load all 14 PC bits from immediate.
// RULE13: Program memory pages are 256 words; page zero starts at zero.
// RULE14: Short branch replaces only PC low eight bits.
// RULE15: Short branch at last page word lands in the next page.
// RULE16: Zero-page call loads 6-bit immediate, clears PC bits 13 to 6.
// RULE17: Table branch target comes from 4-bit immediate, A and B.
// RULE18: Pattern fetch with bit 8 set writes data into A and B.
// RULE19: Pattern fetch with bit 9 set writes data into both port registers.
// RULE20: Both bits set update A/B and both ports in one instruction.
// RULE21: Pattern fetch leaves PC at its normal increment.
// RULE22: Only unmasked interrupt sources may raise the standby wake request.
package cpu_core_pkg;

  localparam int PC_W = 14;
  localparam int RAM_AW = 10;
  localparam int DIG_W = 4;
  localparam int ROM_W = 10;
  localparam int PAGE_BITS = 8;
  localparam int ZPAGE_BITS = 6;
  localparam int MEMREG_BASE = 10'h020;
  localparam int MEMREG_DIGITS = 16;
  localparam int PAT_ACC_BIT = 8;
  localparam int PAT_PORT_BIT = 9;
  localparam int IRQ_N = 4;
  localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
  localparam logic [DIG_W-1:0] REG_RESET = 4'h0;

  // Operation class presented by the decoder each executed cycle
  typedef enum logic [3:0] {
    OP_NONE,
    OP_STANDBY,
    OP_STOP,
    OP_LONG_JUMP,
    OP_SHORT_BRANCH,
    OP_ZERO_CALL,
    OP_TABLE_BRANCH,
    OP_PATTERN,
    OP_RAM_INDIRECT,
    OP_RAM_DIRECT,
    OP_MEMREG_LOAD,
    OP_MEMREG_EXCHANGE
  } op_e;

  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_STANDBY,
    MODE_STOP
  } power_e;

  // One decoded instruction
  typedef struct packed {
    logic valid;
    op_e op;
    logic [PC_W-1:0] imm;
  } instr_s;

  // Working registers the addressing logic reads
  typedef struct packed {
    logic [DIG_W-1:0] acc;
    logic [DIG_W-1:0] b;
    logic [1:0] w;
    logic [DIG_W-1:0] x;
    logic [DIG_W-1:0] y;
  } regs_s;

  // RAM access request
  typedef struct packed {
    logic valid;
    logic [RAM_AW-1:0] addr;
  } ram_req_s;

endpackage

//--- logic/power_ctrl.sv
// Low power mode controller: standby and stop sequencing
`timescale 1ns/1ps
module power_ctrl
  import cpu_core_pkg::*;
#(
  parameter int IRQ_N_P = IRQ_N
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic standby_cmd_in,
  input wire logic stop_cmd_in,
  input wire logic [IRQ_N_P-1:0] irq_flag_in,
  input wire logic [IRQ_N_P-1:0] irq_mask_in,
  output cpu_core_pkg::power_e mode_out,
  output logic wake_out,
  output logic irq_req_out
);

  power_e mode_reg;
  logic any_req;

  // Masked sources never form a request
  assign any_req = |(irq_flag_in & ~irq_mask_in); // [RULE22]
  // Interrupt logic is dead while the oscillator is stopped
  assign irq_req_out = any_req && (mode_reg != MODE_STOP); // [RULE6]
  assign wake_out = (mode_reg == MODE_STANDBY) && any_req; // [RULE4]
  assign mode_out = mode_reg;

  // Mode register; reset clears every mode
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_reg <= MODE_ACTIVE; // [RULE3] [RULE7]
    end else begin
      unique case (mode_reg)
        MODE_ACTIVE: begin
          if (stop_cmd_in) begin
            mode_reg <= MODE_STOP; // [RULE6]
          end else if (standby_cmd_in) begin
            mode_reg <= MODE_STANDBY; // [RULE1]
          end
        end
        MODE_STANDBY: begin
          if (any_req) begin
            mode_reg <= MODE_ACTIVE; // [RULE4]
          end
        end
        // Only the asynchronous reset leaves stop
        MODE_STOP: mode_reg <= MODE_STOP; // [RULE7]
      endcase
    end
  end

endmodule

//--- logic/cpu_core_ctrl.sv
// CPU core control: power modes, RAM and ROM addressing, pattern fetch
`timescale 1ns/1ps
module cpu_core_ctrl
  import cpu_core_pkg::*;
#(
  parameter int IRQ_N_P = IRQ_N
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input cpu_core_pkg::instr_s instr_in,
  input cpu_core_pkg::regs_s regs_in,
  input wire logic int_enable_in,
  input wire logic [IRQ_N_P-1:0] irq_flag_in,
  input wire logic [IRQ_N_P-1:0] irq_mask_in,
  input wire logic [ROM_W-1:0] rom_data_in,
  output logic [PC_W-1:0] pc_out,
  output logic [PC_W-1:0] rom_addr_out,
  output cpu_core_pkg::ram_req_s ram_req_out,
  output logic exec_en_out,
  output logic osc_run_out,
  output logic periph_run_out,
  output logic irq_service_out,
  output logic acc_we_out,
  output logic [DIG_W-1:0] acc_data_out,
  output logic [DIG_W-1:0] b_data_out,
  output logic [DIG_W-1:0] first_output_port_out,
  output logic [DIG_W-1:0] second_output_port_out,
  output logic regs_lost_out
);

  //--------------------------------------------------------------
  // Power mode
  //--------------------------------------------------------------
  power_e mode;
  logic wake;
  logic irq_req;
  logic active;
  logic do_exec;

  power_ctrl #(
    .IRQ_N_P(IRQ_N_P)
  ) u_power (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .standby_cmd_in(do_exec && instr_in.op == OP_STANDBY),
    .stop_cmd_in(do_exec && instr_in.op == OP_STOP),
    .irq_flag_in(irq_flag_in),
    .irq_mask_in(irq_mask_in),
    .mode_out(mode),
    .wake_out(wake),
    .irq_req_out(irq_req)
  );

  assign active = (mode == MODE_ACTIVE);
  // Instruction clock gated in both low power modes
  assign exec_en_out = active; // [RULE1]
  assign do_exec = active && instr_in.valid;
  // Oscillator runs in standby, stops in stop
  assign osc_run_out = (mode != MODE_STOP); // [RULE1] [RULE6]
  assign periph_run_out = (mode != MODE_STOP); // [RULE1] [RULE6]

  //--------------------------------------------------------------
  // Interrupt service decision
  //--------------------------------------------------------------
  // Serviced only when enabled; otherwise the request stays pending
  // upstream and execution just carries on.
  assign irq_service_out = active && irq_req && int_enable_in; // [RULE4]

  //--------------------------------------------------------------
  // Address helpers
  //--------------------------------------------------------------
  function automatic logic [PC_W-1:0] table_addr(
    input logic [DIG_W-1:0] imm4,
    input logic [DIG_W-1:0] a,
    input logic [DIG_W-1:0] bb
  );
    table_addr = {2'b00, imm4, bb, a}; // [RULE17]
  endfunction

  function automatic logic is_memreg(input op_e op);
    is_memreg = (op == OP_MEMREG_LOAD) || (op == OP_MEMREG_EXCHANGE);
  endfunction

  //--------------------------------------------------------------
  // Program counter
  //--------------------------------------------------------------
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [PC_W-1:0] pc_inc;

  // Increment first: a short branch at 256n+255 sees the next page
  assign pc_inc = pc_reg + 14'h0001; // [RULE15]

  // Target selection per branch kind
  always_comb begin
    pc_next = pc_inc; // [RULE5] [RULE21]
    unique case (instr_in.op)
      OP_LONG_JUMP: pc_next = instr_in.imm; // [RULE12]
      OP_SHORT_BRANCH: pc_next = {pc_inc[PC_W-1:PAGE_BITS],
        instr_in.imm[PAGE_BITS-1:0]}; // [RULE13] [RULE14] [RULE15]
      OP_ZERO_CALL: pc_next = {{(PC_W-ZPAGE_BITS){1'b0}},
        instr_in.imm[ZPAGE_BITS-1:0]}; // [RULE16]
      OP_TABLE_BRANCH: pc_next = table_addr(instr_in.imm[DIG_W-1:0],
        regs_in.acc, regs_in.b); // [RULE17]
      default: pc_next = pc_inc;
    endcase
  end

  // PC frozen while not executing
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc_reg <= PC_RESET; // [RULE3]
    end else if (do_exec) begin
      pc_reg <= pc_next; // [RULE2]
    end
  end
  assign pc_out = pc_reg;

  // Pattern fetch reads the table address; else fetch at PC
  assign rom_addr_out = (instr_in.op == OP_PATTERN) ?
    table_addr(instr_in.imm[DIG_W-1:0], regs_in.acc, regs_in.b) :
    pc_reg;

  //--------------------------------------------------------------
  // RAM addressing
  //--------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ram_req_out <= '0;
    end else begin
      ram_req_out.valid <= 1'b0; // RAM untouched outside execution
      if (do_exec) begin
        unique case (instr_in.op)
          OP_RAM_INDIRECT: begin
            ram_req_out.valid <= 1'b1;
            ram_req_out.addr <= {regs_in.w, regs_in.x,
              regs_in.y}; // [RULE9]
          end
          OP_RAM_DIRECT: begin
            ram_req_out.valid <= 1'b1;
            ram_req_out.addr <= instr_in.imm[RAM_AW-1:0]; // [RULE10]
          end
          OP_MEMREG_LOAD, OP_MEMREG_EXCHANGE: begin
            // These two operations form the window address; direct and indirect modes reach it too
            ram_req_out.valid <= is_memreg(instr_in.op); // [RULE11]
            ram_req_out.addr <= RAM_AW'(MEMREG_BASE) |
              {6'h00, instr_in.imm[3:0]}; // [RULE11]
          end
          default: ram_req_out.valid <= 1'b0;
        endcase
      end
    end
  end

  //--------------------------------------------------------------
  // Pattern fetch
  //--------------------------------------------------------------
  logic pat;
  assign pat = do_exec && instr_in.op == OP_PATTERN;

  // Accumulator and B load, flagged by bit 8
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_we_out <= 1'b0;
      acc_data_out <= REG_RESET;
      b_data_out <= REG_RESET;
    end else begin
      acc_we_out <= pat && rom_data_in[PAT_ACC_BIT]; // [RULE18] [RULE20]
      if (pat && rom_data_in[PAT_ACC_BIT]) begin
        acc_data_out <= rom_data_in[3:0]; // [RULE18]
        b_data_out <= rom_data_in[7:4]; // [RULE18]
      end
    end
  end

  // Port output registers, flagged by bit 9; held in standby
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      first_output_port_out <= REG_RESET;
      second_output_port_out <= REG_RESET;
    end else if (pat && rom_data_in[PAT_PORT_BIT]) begin
      first_output_port_out <= rom_data_in[3:0]; // [RULE19] [RULE20]
      second_output_port_out <= rom_data_in[7:4]; // [RULE19] [RULE20]
    end
  end

  //--------------------------------------------------------------
  // Stop recovery indication
  //--------------------------------------------------------------
  // Working registers are not guaranteed after stop; RAM is never
  // cleared here, so its contents survive. A plain flag tells
  // software-side logic to treat the register file as stale.
  logic stop_seen_reg;
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stop_seen_reg <= 1'b1; // [RULE8]
    end else if (do_exec) begin
      stop_seen_reg <= 1'b0;
    end
  end
  assign regs_lost_out = stop_seen_reg; // [RULE8]

endmodule

//--- verification/cpu_core_ctrl_assertions.sv
// Concurrent checks on the CPU core control ports
`timescale 1ns/1ps
module cpu_core_ctrl_assertions
  import cpu_core_pkg::*;
#(
  parameter int IRQ_N_P = IRQ_N
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input cpu_core_pkg::instr_s instr_in,
  input cpu_core_pkg::regs_s regs_in,
  input wire logic int_enable_in,
  input wire logic [IRQ_N_P-1:0] irq_flag_in,
  input wire logic [IRQ_N_P-1:0] irq_mask_in,
  input wire logic [ROM_W-1:0] rom_data_in,
  input wire logic [PC_W-1:0] pc_out,
  input cpu_core_pkg::ram_req_s ram_req_out,
  input wire logic exec_en_out,
  input wire logic osc_run_out,
  input wire logic periph_run_out,
  input wire logic irq_service_out,
  input wire logic acc_we_out,
  input wire logic [DIG_W-1:0] acc_data_out,
  input wire logic [DIG_W-1:0] b_data_out,
  input wire logic [DIG_W-1:0] first_output_port_out,
  input wire logic [DIG_W-1:0] second_output_port_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic go, sb, unm;
  logic [PC_W-1:0] nxt, br, zc;
  logic [RAM_AW-1:0] ind;
  logic [7:0] pat;
  // Targets from this cycle's inputs, so $past sees plain signals
  // The release edge still sees reset low, so nothing executes there
  assign go = resetn_in && exec_en_out && instr_in.valid;
  assign sb = !exec_en_out && osc_run_out;
  assign unm = |(irq_flag_in & ~irq_mask_in);
  assign nxt = pc_out + 14'h0001;
  assign br = {nxt[13:8], instr_in.imm[7:0]};
  assign zc = {8'h00, instr_in.imm[5:0]};
  assign ind = {regs_in.w, regs_in.x, regs_in.y};
  assign pat = rom_data_in[7:0];
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_LONG_JUMP: assert property (
    go && instr_in.op == OP_LONG_JUMP |=> pc_out == $past(instr_in.imm))
    else $error("long jump target wrong");
  AST_SHORT_BRANCH: assert property (
    go && instr_in.op == OP_SHORT_BRANCH |=> pc_out == $past(br))
    else $error("short branch target wrong");
  AST_ZERO_CALL: assert property (
    go && instr_in.op == OP_ZERO_CALL |=> pc_out == $past(zc))
    else $error("zero page call target wrong");
  AST_RAM_INDIRECT: assert property (
    go && instr_in.op == OP_RAM_INDIRECT |=> ram_req_out == {1'b1, $past(ind)})
    else $error("indirect ram address wrong");
  AST_PAT_ACC: assert property (
    go && instr_in.op == OP_PATTERN && rom_data_in[8] |=> acc_we_out
    && {b_data_out, acc_data_out} == $past(pat))
    else $error("pattern data not in a and b");
  AST_PAT_PORT: assert property (
    go && instr_in.op == OP_PATTERN && rom_data_in[9] |=>
    {second_output_port_out, first_output_port_out} == $past(pat))
    else $error("pattern data not on ports");
  AST_PAT_PC: assert property (
    go && instr_in.op == OP_PATTERN |=> pc_out == $past(nxt))
    else $error("pattern fetch moved pc");
  AST_SLEEP: assert property (
    go && instr_in.op == OP_STANDBY |=> sb && periph_run_out)
    else $error("standby not entered");
  AST_STANDBY_HOLD: assert property (
    sb && !unm |=> !exec_en_out && $stable(pc_out) && !acc_we_out)
    else $error("standby state changed");
  AST_WAKE: assert property (
    sb && unm |=> exec_en_out)
    else $error("no wake from standby");
  AST_STOP: assert property (
    (go && instr_in.op == OP_STOP) || !osc_run_out |=>
    !osc_run_out && !periph_run_out && !exec_en_out)
    else $error("stop mode left or not entered");
  AST_SERVICE: assert property (
    irq_service_out == (exec_en_out && unm && int_enable_in))
    else $error("interrupt service wrong");
  // Main scenarios reached
  cover property (go && instr_in.op == OP_PATTERN && &rom_data_in[9:8]);
  cover property (sb && unm);
  cover property (!osc_run_out);
endmodule

bind cpu_core_ctrl cpu_core_ctrl_assertions #(.IRQ_N_P(IRQ_N_P)) chk (.*);

//--- verification/cpu_core_ctrl_test.sv
// Self-checking bench for the CPU core control block
`timescale 1ns/1ps
module cpu_core_ctrl_test;
  import cpu_core_pkg::*;
  // ----------------------------------------
  // Signals, model state and counters
  // ----------------------------------------
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  instr_s instr_in = '0;
  regs_s regs_in = '0;
  logic int_enable_in = 1'b0;
  logic [3:0] irq_flag_in = '0;
  logic [3:0] irq_mask_in = '1;
  logic [9:0] rom_data_in = '0;
  logic [13:0] pc_out, rom_addr_out;
  ram_req_s ram_req_out;
  logic exec_en_out, osc_run_out, periph_run_out, irq_service_out;
  logic acc_we_out, regs_lost_out;
  logic [3:0] acc_data_out, b_data_out;
  logic [3:0] first_output_port_out, second_output_port_out;
  logic [31:0] seed = 32'd71;
  logic [31:0] r;
  logic [31:0] r2;
  op_e op;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc_n = 0;
  logic [13:0] e_pc = '0;
  logic [1:0] e_md = '0; // 0 active, 1 standby, 2 stop
  ram_req_s e_rq = '0;
  logic e_we = 1'b0;
  logic e_ls = 1'b1;
  logic [7:0] e_ab = '0;
  logic [7:0] e_pt = '0;

  cpu_core_ctrl dut (.*);

  always #12.5 mclk_in = ~mclk_in;

  // Hang guard, well above the length of the run
  always @(posedge mclk_in) begin
    cyc_n++;
    if (cyc_n == 8000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Functions and tasks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Next pc; every non-branch steps by one
  function automatic logic [13:0] target(instr_s i, logic [13:0] p, regs_s g);
    logic [13:0] n;
    n = p + 14'h0001;
    case (i.op)
      OP_LONG_JUMP: return i.imm;
      OP_SHORT_BRANCH: return {n[13:8], i.imm[7:0]};
      OP_ZERO_CALL: return {8'h00, i.imm[5:0]};
      OP_TABLE_BRANCH: return {2'b00, i.imm[3:0], g.b, g.acc};
      default: return n;
    endcase
  endfunction

  // Address holds its last value while the request is idle
  function automatic ram_req_s ram(instr_s i, regs_s g, ram_req_s q);
    case (i.op)
      OP_RAM_INDIRECT: return {1'b1, g.w, g.x, g.y};
      OP_RAM_DIRECT: return {1'b1, i.imm[9:0]};
      OP_MEMREG_LOAD, OP_MEMREG_EXCHANGE:
        return {1'b1, 10'(MEMREG_BASE) | {6'h00, i.imm[3:0]}};
      default: return {1'b0, q.addr};
    endcase
  endfunction

  task automatic check(string nm, logic [13:0] e, logic [13:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One cycle: advance the model on what the design sampled, drive anew
  task automatic cyc(instr_s i, logic [9:0] rom, logic [3:0] msk);
    @(posedge mclk_in);
    e_rq.valid = 1'b0;
    e_we = 1'b0;
    if (e_md == 2'd1 && |(irq_flag_in & ~irq_mask_in))
      e_md = 2'd0;
    else if (e_md == 2'd0 && instr_in.valid) begin
      e_pc = target(instr_in, e_pc, regs_in);
      e_rq = ram(instr_in, regs_in, e_rq);
      e_ls = 1'b0;
      if (instr_in.op == OP_STANDBY) e_md = 2'd1;
      if (instr_in.op == OP_STOP) e_md = 2'd2;
      if (instr_in.op == OP_PATTERN && rom_data_in[8]) e_we = 1'b1;
      if (e_we) e_ab = rom_data_in[7:0];
      if (instr_in.op == OP_PATTERN && rom_data_in[9]) e_pt = rom_data_in[7:0];
    end
    r = rnd();
    instr_in <= i;
    regs_in <= r[17:0];
    int_enable_in <= r[20];
    irq_flag_in <= r[24:21];
    irq_mask_in <= msk;
    rom_data_in <= rom;
    @(negedge mclk_in);
    check("pc", e_pc, pc_out);
    check("ram", e_rq, ram_req_out);
    check("we", e_we, acc_we_out);
    check("lost", e_ls, regs_lost_out);
    check("ab", e_ab, {b_data_out, acc_data_out});
    check("port", e_pt, {second_output_port_out, first_output_port_out});
    check("mode", {e_md == 0, e_md != 2}, {exec_en_out, osc_run_out});
    check("svc", e_md == 0 && |(irq_flag_in & ~irq_mask_in) && int_enable_in,
          irq_service_out);
    if (e_md == 0 && instr_in.valid && instr_in.op == OP_PATTERN)
      check("rom", {2'b00, instr_in.imm[3:0], regs_in.b, regs_in.acc},
            rom_addr_out);
  endtask

  // Reset from any mode; outputs return to their reset values
  task automatic rst(int n);
    @(posedge mclk_in);
    resetn_in <= 1'b0;
    repeat (n) @(posedge mclk_in);
    resetn_in <= 1'b1;
    {e_pc, e_md, e_ab, e_pt} = '0;
    e_rq = '0;
    e_ls = 1'b1;
    @(negedge mclk_in);
    check("lost", 1'b1, regs_lost_out);
    check("mode", 2'b11, {exec_en_out, osc_run_out});
    check("pc", 14'h0000, pc_out);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst(16);
    // Short branch from the last word of page zero
    cyc('{1'b1, OP_LONG_JUMP, 14'h00ff}, 10'h000, 4'hf);
    cyc('{1'b1, OP_SHORT_BRANCH, 14'h0010}, 10'h000, 4'hf);
    for (int k = 0; k < 4; k++)
      cyc('{1'b1, OP_PATTERN, 14'h0005}, {k[1:0], 8'h5a}, 4'hf);
    // Long jump through memory-register exchange once each, standby last so nothing after it is swallowed
    for (int k = 3; k < 13; k++) begin
      op = (k < 12) ? op_e'(k) : OP_STANDBY;
      cyc('{1'b1, op, 14'h3ff5}, 10'h3c3, 4'hf);
    end
    // Masked flags keep standby, unmasked ones wake it
    repeat (5) cyc('{1'b1, OP_NONE, 14'h0000}, 10'h0ff, 4'hf);
    repeat (3) cyc('{1'b1, OP_NONE, 14'h0000}, 10'h0ff, 4'h0);
    repeat (3000) begin
      r = rnd();
      op = op_e'(r[3:0] % 4'd12);
      if (op == OP_STOP) op = OP_STANDBY;
      r2 = rnd();
      cyc('{r[4] | r[5], op, r[19:6]}, r[29:20], r[31:28] | r2[3:0]);
    end
    cyc('{1'b1, OP_STANDBY, 14'h0000}, 10'h000, 4'hf);
    cyc('{1'b1, OP_NONE, 14'h0000}, 10'h000, 4'hf);
    rst(2);
    cyc('{1'b1, OP_STOP, 14'h0000}, 10'h000, 4'h0);
    repeat (4) cyc('{1'b1, OP_LONG_JUMP, 14'h1234}, 10'h3ff, 4'h0);
    rst(8);
    repeat (3) cyc('{1'b1, OP_ZERO_CALL, 14'h3fff}, 10'h000, 4'hf);
    print_verdict();
  end
endmodule
